// ==== inc/rxs_pkg.sv ====
// types shared by the receive signal strength block
// assumes nothing beyond the header of constants
package rxs_pkg;
  typedef enum logic [1:0] {
    RXS_LAT_PREAMBLE = 2'h0,
    RXS_LAT_SYNC = 2'h1,
    RXS_LAT_BITS = 2'h2
  } rxs_lat_src_t;
  typedef enum logic [1:0] {
    RXS_CAL_IDLE = 2'h0,
    RXS_CAL_RUN = 2'h1,
    RXS_CAL_DONE = 2'h3
  } rxs_cal_t;
endpackage

// ==== inc/rxs_regs.svh ====
// register offsets, reset values and timing counts
// assumes a 50 MHz pclk and a 32-bit APB slave
`ifndef RXS_REGS_SVH
`define RXS_REGS_SVH
`define RXS_OFF_CTRL 12'h000
`define RXS_OFF_CFG 12'h004
`define RXS_OFF_STEP 12'h008
`define RXS_OFF_OFFSET 12'h00C
`define RXS_OFF_THRESH 12'h010
`define RXS_OFF_FRR 12'h014
`define RXS_OFF_QUERY 12'h018
`define RXS_OFF_STATUS 12'h01C
`define RXS_OFF_CUR 12'h020
`define RXS_OFF_LAT 12'h024
`define RXS_OFF_CAL 12'h028
`define RXS_OFF_CRC 12'h02C
`define RXS_OFFSET_ZERO 7'h32
`define RXS_BT_DEFAULT 4'h5
`define RXS_MIN_LATCH_BITS 8'h04
`define RXS_MIN_AVG_BITS 8'h07
`define RXS_QUERY_NS 33000
`define RXS_CLK_NS 20
`define RXS_QUERY_CYC ((`RXS_QUERY_NS + `RXS_CLK_NS - 1) / `RXS_CLK_NS)
`define RXS_CAL_INIT_MS 250
`define RXS_CAL_RE_MS 100
`define RXS_CYC_PER_MS 50000
`define RXS_CRC_INIT 16'hFFFF
`define RXS_CRC_POLY 16'h1021
`endif

// ==== rtl/rxs_strength.sv ====
// signal strength measurement, latch, threshold, jump, calibration and crc
// assumes raw strength samples and modem events from the demodulator
`timescale 1ns/1ps
`include "rxs_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - strength code counts in half-decibel steps.
// - one latched strength value per packet, at a configured moment.
// - fast response registers can mirror the latched value, readable at once.
// - status query returns latched value and current value at processing time.
// - query complete flag rises 33 us after the query; host then reads.
// - latch on preamble, sync, or a bit count of at least four.
// - option: update every bit, or average four bits each four bits.
// - with averaging, latch no earlier than seven bits after receive start.
// - latched values clear on receive entry and stay readable afterwards.
// - latched value reads zero between clear and new latch.
// - strength rise or fall beyond step threshold flags a jump.
// - optional automatic modem and receiver reset on jump.
// - jump detection disabled after reset until software enables it.
// - seven-bit offset in 1 dB steps, 7'h32 means no offset.
// - threshold exceed flag, latched and unlatched, routable to outputs.
// - gain loop settles within a bit or 2 us; this block has no gain loop.
// - frequency correction ranges 0.25 and 0.35 of IF bandwidth; this block has no frequency correction.
// - image calibration takes 250 ms initially, 100 ms on recalibration.
// - gaussian shaping defaults to bandwidth-time 0.5, programmable.
// - crc appended on transmit and checked on receive; this block only checks received bits and appends nothing.
module rxs_strength #(
  parameter int CAL_INIT_CYC = `RXS_CAL_INIT_MS * `RXS_CYC_PER_MS,
  parameter int CAL_RE_CYC = `RXS_CAL_RE_MS * `RXS_CYC_PER_MS
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // modem side, asynchronous to pclk
  input wire logic bit_clk,
  input wire logic rx_on,
  input wire logic preamble_det,
  input wire logic sync_det,
  input wire logic [7:0] raw_strength,
  input wire logic crc_bit,
  input wire logic crc_bit_valid,
  // notifications
  output logic jump_out,
  output logic thresh_out,
  output logic thresh_latched_out,
  output logic rx_reset_out,
  output logic query_done_out,
  output logic cal_busy_out,
  output logic [3:0] shaping_bt
);
  import rxs_pkg::*;

  initial begin
    if (CAL_INIT_CYC < 1 || CAL_RE_CYC < 1) $error("calibration counts must be positive");
  end

  localparam int QCYC = `RXS_QUERY_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers for the single-bit pins
  logic [5:0] s1, s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 6'h00;
      s2 <= 6'h00;
    end else begin
      s1 <= {crc_bit_valid, crc_bit, bit_clk, rx_on, preamble_det, sync_det};
      s2 <= s1;
    end
  end
  logic [7:0] raw_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) raw_q <= 8'h00;
    else raw_q <= raw_strength;
  end
  logic [7:0] raw_s;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) raw_s <= 8'h00;
    else raw_s <= raw_q;
  end
  logic crcv_s, crcb_s, bclk_s, rx_s, pre_s, syn_s;
  assign {crcv_s, crcb_s, bclk_s, rx_s, pre_s, syn_s} = s2;

  // edge detection on synchronised levels
  logic bclk_d, rx_d, pre_d, syn_d, crcv_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) {bclk_d, rx_d, pre_d, syn_d, crcv_d} <= 5'h00;
    else {bclk_d, rx_d, pre_d, syn_d, crcv_d} <= {bclk_s, rx_s, pre_s, syn_s, crcv_s};
  end
  wire bit_tick = bclk_s & ~bclk_d;
  wire rx_start = rx_s & ~rx_d;
  wire pre_rise = pre_s & ~pre_d;
  wire syn_rise = syn_s & ~syn_d;
  wire crc_tick = crcv_s & ~crcv_d;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  logic [1:0] lat_src;
  logic avg4;
  logic [7:0] lat_bits;
  logic jump_en, jump_rst_en;
  logic [7:0] step_thr;
  logic [6:0] offset;
  logic [7:0] thr;
  logic [3:0] frr_sel;
  logic [3:0] bt;
  wire wr = psel & penable & pwrite;
  wire rd_acc = psel & ~penable;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // software writes to configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat_src <= RXS_LAT_PREAMBLE;
      avg4 <= 1'b0;
      lat_bits <= `RXS_MIN_LATCH_BITS;
      jump_en <= 1'b0;
      jump_rst_en <= 1'b0;
      step_thr <= 8'h0C;
      offset <= `RXS_OFFSET_ZERO;
      thr <= 8'hFF;
      frr_sel <= 4'h0;
      bt <= `RXS_BT_DEFAULT;
    end else if (wr) begin
      if (hit(paddr, `RXS_OFF_CFG)) begin
        lat_src <= pwdata[1:0];
        avg4 <= pwdata[2];
        lat_bits <= pwdata[15:8];
        bt <= pwdata[19:16];
      end
      if (hit(paddr, `RXS_OFF_STEP)) begin
        jump_en <= pwdata[0];
        jump_rst_en <= pwdata[1];
        step_thr <= pwdata[15:8];
      end
      if (hit(paddr, `RXS_OFF_OFFSET)) offset <= pwdata[6:0];
      if (hit(paddr, `RXS_OFF_THRESH)) thr <= pwdata[7:0];
      if (hit(paddr, `RXS_OFF_FRR)) frr_sel <= pwdata[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // current strength: offset in 1 dB = 2 codes, per bit or 4-bit average
  logic [8:0] comp;
  always_comb begin
    comp = 9'({1'b0, raw_s} + {1'b0, offset, 1'b0});
    if ({1'b0, offset, 1'b0} < 9'({`RXS_OFFSET_ZERO, 1'b0}) + 9'({1'b0, raw_s}) &&
        comp < 9'({`RXS_OFFSET_ZERO, 1'b0}))
      comp = 9'h000;
    else
      comp = 9'(comp - 9'({`RXS_OFFSET_ZERO, 1'b0}));
  end
  wire [7:0] comp_sat = comp[8] ? 8'hFF : comp[7:0];

  logic [7:0] cur;
  logic [9:0] acc;
  logic [1:0] ph;
  logic [7:0] bitcnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= 8'h00;
      acc <= 10'h000;
      ph <= 2'h0;
    end else if (rx_start) begin
      acc <= 10'h000;
      ph <= 2'h0;
    end else if (bit_tick) begin
      if (!avg4) cur <= comp_sat;
      else begin
        ph <= 2'(ph + 2'h1);
        if (ph == 2'h3) begin
          cur <= 8'((acc + 10'({2'h0, comp_sat})) >> 2);
          acc <= 10'h000;
        end else acc <= 10'(acc + 10'({2'h0, comp_sat}));
      end
    end
  end

  // bits since receive start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bitcnt <= 8'h00;
    else if (rx_start) bitcnt <= 8'h00;
    else if (bit_tick && bitcnt != 8'hFF) bitcnt <= 8'(bitcnt + 8'h01);
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch: one per packet, cleared on receive entry
  logic [7:0] lat;
  logic latched, lat_pend;
  wire [7:0] min_bits = avg4 ? `RXS_MIN_AVG_BITS : `RXS_MIN_LATCH_BITS;
  wire [7:0] tgt_bits = (lat_bits < min_bits) ? min_bits : lat_bits;
  wire lat_evt = (lat_src == RXS_LAT_PREAMBLE && pre_rise) ||
                 (lat_src == RXS_LAT_SYNC && syn_rise) ||
                 (lat_src == RXS_LAT_BITS && bit_tick);
  wire bits_ok = bitcnt >= min_bits;
  wire lat_fire = rx_s && !latched && (lat_src == RXS_LAT_BITS ?
                  (bitcnt >= tgt_bits) : ((lat_evt || lat_pend) && bits_ok));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lat <= 8'h00;
      latched <= 1'b0;
      lat_pend <= 1'b0;
    end else if (rx_start) begin
      lat <= 8'h00;
      latched <= 1'b0;
      lat_pend <= 1'b0;
    end else if (lat_fire) begin
      lat <= cur;
      latched <= 1'b1;
      lat_pend <= 1'b0;
    end else if (lat_evt && !latched && lat_src != RXS_LAT_BITS) lat_pend <= 1'b1;
  end

  a_latch_holds: assert property (@(posedge pclk) disable iff (!presetn)
    latched && !rx_start |=> $stable(lat)) else $error("latched value moved");
  a_latch_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rx_start |=> lat == 8'h00 && !latched) else $error("latch not cleared");
  a_latch_min: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(latched) |-> $past(bitcnt) >= (avg4 ? 8'h07 : 8'h04))
    else $error("latch too early");

  ////////////////////////////////////////////////////////////////////////////
  // jump and threshold detection, registered notifications
  logic [7:0] prev;
  wire [7:0] diff = (cur > prev) ? 8'(cur - prev) : 8'(prev - cur);
  wire jump_hit = jump_en && rx_s && bit_tick && bitcnt > min_bits && diff > step_thr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev <= 8'h00;
      jump_out <= 1'b0;
      rx_reset_out <= 1'b0;
    end else begin
      if (bit_tick) prev <= cur;
      jump_out <= jump_hit;
      rx_reset_out <= jump_hit && jump_rst_en;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      thresh_out <= 1'b0;
      thresh_latched_out <= 1'b0;
    end else begin
      thresh_out <= cur > thr;
      if (cur > thr) thresh_latched_out <= 1'b1;
      else if (rx_start) thresh_latched_out <= 1'b0;
    end
  end
  a_jump_off: assert property (@(posedge pclk) disable iff (!presetn)
    !jump_en |=> !jump_out) else $error("jump while disabled");
  a_jump_reset: assert property (@(posedge pclk) disable iff (!presetn)
    rx_reset_out |-> jump_out && $past(jump_rst_en)) else $error("stray receiver reset");

  ////////////////////////////////////////////////////////////////////////////
  // modem status query: snapshot current, complete after 33 us
  logic [15:0] qcnt;
  logic [7:0] q_cur, q_lat;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qcnt <= 16'h0000;
      q_cur <= 8'h00;
      q_lat <= 8'h00;
      query_done_out <= 1'b1;
    end else if (wr && hit(paddr, `RXS_OFF_QUERY)) begin
      q_cur <= cur;
      q_lat <= lat;
      qcnt <= 16'(QCYC - 1);
      query_done_out <= 1'b0;
    end else if (qcnt != 16'h0000) qcnt <= 16'(qcnt - 16'h0001);
    else query_done_out <= 1'b1;
  end
  a_query_wait: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(query_done_out) |-> !query_done_out [*8]) else $error("query done early");

  ////////////////////////////////////////////////////////////////////////////
  // image calibration timer
  rxs_cal_t cal_st;
  logic [31:0] cal_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st <= RXS_CAL_IDLE;
      cal_cnt <= 32'h00000000;
      cal_busy_out <= 1'b0;
    end else unique case (cal_st)
      RXS_CAL_IDLE, RXS_CAL_DONE: begin
        if (wr && hit(paddr, `RXS_OFF_CAL) && pwdata[0]) begin
          cal_cnt <= (cal_st == RXS_CAL_DONE) ? 32'(CAL_RE_CYC - 1) : 32'(CAL_INIT_CYC - 1);
          cal_st <= RXS_CAL_RUN;
          cal_busy_out <= 1'b1;
        end
      end
      RXS_CAL_RUN: begin
        if (cal_cnt == 32'h00000000) begin
          cal_st <= RXS_CAL_DONE;
          cal_busy_out <= 1'b0;
        end else cal_cnt <= 32'(cal_cnt - 32'h00000001);
      end
      default: cal_st <= RXS_CAL_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // crc-16 over received bits, preset to all ones on receive start
  logic [15:0] crc;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) crc <= `RXS_CRC_INIT;
    else if (rx_start) crc <= `RXS_CRC_INIT;
    else if (crc_tick)
      crc <= {crc[14:0], 1'b0} ^ ((crc[15] ^ crcb_s) ? `RXS_CRC_POLY : 16'h0000);
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb read path, one wait-free access, unmapped reads zero with error
  logic [31:0] next_prdata;
  logic next_err;
  always_comb begin
    next_prdata = 32'h00000000;
    next_err = 1'b0;
    unique case (paddr)
      `RXS_OFF_CTRL: next_prdata = {31'h0, rx_s};
      `RXS_OFF_CFG: next_prdata = {12'h0, bt, lat_bits, 5'h0, avg4, lat_src};
      `RXS_OFF_STEP: next_prdata = {16'h0, step_thr, 6'h0, jump_rst_en, jump_en};
      `RXS_OFF_OFFSET: next_prdata = {25'h0, offset};
      `RXS_OFF_THRESH: next_prdata = {24'h0, thr};
      `RXS_OFF_FRR: next_prdata = {4{frr_sel[3], frr_sel[2], frr_sel[1], frr_sel[0],
                                     4'h0}} & {32{1'b0}} | {28'h0, frr_sel} |
                                  {frr_sel[3] ? lat : 8'h00, frr_sel[2] ? lat : 8'h00,
                                   frr_sel[1] ? lat : 8'h00, 8'h00};
      `RXS_OFF_QUERY: next_prdata = {15'h0, query_done_out, q_lat, q_cur};
      `RXS_OFF_STATUS: next_prdata = {26'h0, cal_busy_out, latched, thresh_latched_out,
                                      thresh_out, jump_out, query_done_out};
      `RXS_OFF_CUR: next_prdata = {24'h0, cur};
      `RXS_OFF_LAT: next_prdata = {frr_sel[0] ? lat : 8'h00, 16'h0, lat};
      `RXS_OFF_CAL: next_prdata = {30'h0, cal_st};
      `RXS_OFF_CRC: next_prdata = {15'h0, crc == 16'h0000, crc};
      default: next_err = 1'b1;
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= rd_acc;
      pslverr <= rd_acc & next_err;
      if (rd_acc) prdata <= next_prdata;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) shaping_bt <= `RXS_BT_DEFAULT;
    else shaping_bt <= bt;
  end
endmodule // rxs_strength

// ==== testbench/rx_modem_signal_strength_tb.sv ====
// bench for the strength block: apb tasks and scenario sequence
// assumes the modem model on the link pins and short calibration counts
`timescale 1ns/1ps
`include "rxs_regs.svh"

module rx_modem_signal_strength_tb;
  import rxs_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, frame = 1'b0, bit_clk, preamble_det, sync_det;
  logic [7:0] level = 8'h64, raw_strength;
  logic jump_out, thresh_out, thresh_latched_out, rx_reset_out, query_done_out, cal_busy_out;
  logic [3:0] shaping_bt;
  logic crc_b = 1'b0, crc_v = 1'b0;
  int bad_count = 0, compares = 0, jumps = 0, rsts = 0, qlow = 0, calc = 0, bit_no, i, j;

  // clock
  always #10 pclk = ~pclk;

  rxs_strength #(.CAL_INIT_CYC(100), .CAL_RE_CYC(50)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bit_clk(bit_clk), .rx_on(frame),
    .preamble_det(preamble_det), .sync_det(sync_det), .raw_strength(raw_strength),
    .crc_bit(crc_b), .crc_bit_valid(crc_v), .jump_out(jump_out), .thresh_out(thresh_out),
    .thresh_latched_out(thresh_latched_out), .rx_reset_out(rx_reset_out),
    .query_done_out(query_done_out), .cal_busy_out(cal_busy_out), .shaping_bt(shaping_bt));

  rxs_modem_model i_modem (.frame(frame), .level(level), .bit_clk(bit_clk),
    .preamble_det(preamble_det), .sync_det(sync_det), .raw_strength(raw_strength),
    .bit_no(bit_no));

  // pulse and duration monitors
  always @(posedge pclk) begin
    if (jump_out === 1'b1) jumps++;
    if (rx_reset_out === 1'b1) rsts++;
    if (query_done_out === 1'b0) qlow++;
    if (cal_busy_out === 1'b1) calc++;
  end

  ////////////////////////////////////////
  task test_done;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task hang(input int k, input int lim);
    if (k >= lim) begin
      chk("wait", 32'h0, 32'h1);
      test_done;
    end
  endtask

  // one apb transfer, held until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    hang(k, 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdc(input string n, input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, e, rd & m);
  endtask

  task wait_bits(input int n);
    int t;
    int k;
    t = bit_no + n;
    for (k = 0; k < 4000 && bit_no < t; k++) @(posedge pclk);
    hang(k, 4000);
    repeat (4) @(posedge pclk);
  endtask

  // waits while query done (cal=0) or calibration busy (cal=1) equals v
  task wait_low(input logic cal, input logic v);
    int k;
    repeat (2) @(posedge pclk);
    for (k = 0; k < 3000 && (cal ? cal_busy_out : query_done_out) === v; k++)
      @(posedge pclk);
    hang(k, 3000);
  endtask

  // shifts the n low bits of v, msb first, one valid pulse per bit
  task crc_shift(input logic [15:0] v, input int n);
    int b;
    for (b = n - 1; b >= 0; b--) begin
      crc_b <= v[b];
      repeat (2) @(posedge pclk);
      crc_v <= 1'b1;
      repeat (4) @(posedge pclk);
      crc_v <= 1'b0;
      repeat (4) @(posedge pclk);
    end
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("offset", `RXS_OFF_OFFSET, 32'h7F, 32'h32);
    rdc("thresh", `RXS_OFF_THRESH, 32'hFF, 32'hFF);
    rdc("step", `RXS_OFF_STEP, 32'hFFFF, 32'h0C00);
    rdc("latched", `RXS_OFF_LAT, 32'hFF, 32'h0);
    chk("bt", 32'h5, {28'h0, shaping_bt});
    apb(1'b0, 12'h030, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    // latch sources, then averaging with its longer minimum
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `RXS_OFF_CFG, {12'h0, 4'h5, 8'h04, 5'h0, i == 3, (i == 3) ? 2'h2 : 2'(i)});
      level <= 8'h64;
      frame <= 1'b1;
      wait_bits((i == 3) ? 5 : 2);
      rdc("early", `RXS_OFF_LAT, 32'hFF, 32'h0);
      wait_bits(14);
      rdc("latched", `RXS_OFF_LAT, 32'hFF, 32'h64);
      level <= 8'h70;
      wait_bits(8);
      rdc("held", `RXS_OFF_LAT, 32'hFF, 32'h64);
      rdc("current", `RXS_OFF_CUR, 32'hFF, 32'h70);
      frame <= 1'b0;
      repeat (20) @(posedge pclk);
      rdc("after rx", `RXS_OFF_LAT, 32'hFF, 32'h64);
    end
    // offset, fast register and status query
    level <= 8'h64;
    frame <= 1'b1;
    apb(1'b1, `RXS_OFF_OFFSET, 32'h3A);
    wait_bits(12);
    rdc("offset cur", `RXS_OFF_CUR, 32'hFF, 32'h74);
    apb(1'b1, `RXS_OFF_FRR, 32'h1);
    rdc("fast reg", `RXS_OFF_LAT, 32'hFF000000, 32'h74000000);
    apb(1'b1, `RXS_OFF_FRR, 32'hF);
    rdc("fast regs", `RXS_OFF_FRR, 32'hFFFFFF00, 32'h74747400);
    apb(1'b1, `RXS_OFF_OFFSET, 32'h32);
    wait_bits(6);
    qlow = 0;
    apb(1'b1, `RXS_OFF_QUERY, 32'h0);
    wait_low(1'b0, 1'b0);
    chk("query time", 32'h1, {31'h0, qlow >= 1649 && qlow <= 1651});
    rdc("query", `RXS_OFF_QUERY, 32'h1FFFF, 32'h17464);
    // threshold, then jump disabled and enabled
    apb(1'b1, `RXS_OFF_THRESH, 32'h80);
    level <= 8'h90;
    wait_bits(8);
    chk("thr", 32'h1, {31'h0, thresh_out});
    jumps = 0;
    rsts = 0;
    level <= 8'h20;
    wait_bits(8);
    chk("thr low", 32'h0, {31'h0, thresh_out});
    chk("thr lat", 32'h1, {31'h0, thresh_latched_out});
    chk("no jump", 32'h0, 32'(jumps));
    apb(1'b1, `RXS_OFF_STEP, 32'h0C03);
    level <= 8'h90;
    wait_bits(8);
    chk("jump", 32'h1, {31'h0, jumps > 0});
    chk("rx reset", 32'h1, {31'h0, rsts > 0});
    level <= 8'h20;
    wait_bits(8);
    chk("thr sticky", 32'h1, {31'h0, thresh_latched_out});
    frame <= 1'b0;
    repeat (20) @(posedge pclk);
    frame <= 1'b1;
    wait_bits(2);
    chk("thr clr", 32'h0, {31'h0, thresh_latched_out});
    // crc starts at its initial value, then appending it leaves a zero residue
    rdc("crc init", `RXS_OFF_CRC, 32'h1FFFF, {16'h0, `RXS_CRC_INIT});
    crc_shift(16'h00A5, 8);
    apb(1'b0, `RXS_OFF_CRC, 32'h0);
    crc_shift(rd[15:0], 16);
    rdc("crc residue", `RXS_OFF_CRC, 32'h1FFFF, 32'h10000);
    frame <= 1'b0;
    apb(1'b1, `RXS_OFF_CFG, 32'h00070402);
    @(posedge pclk);
    chk("bt set", 32'h7, {28'h0, shaping_bt});
    // first calibration, then a recalibration
    for (i = 0; i < 2; i++) begin
      calc = 0;
      apb(1'b1, `RXS_OFF_CAL, 32'h1);
      wait_low(1'b1, 1'b1);
      j = (i == 0) ? 100 : 50;
      chk("cal time", 32'h1, {31'h0, calc >= j - 1 && calc <= j + 1});
    end
    test_done;
  end
endmodule // rx_modem_signal_strength_tb

// ==== testbench/rxs_modem_model.sv ====
// modem stand-in: bit clock, detect events and raw strength samples
// assumes the bench raises frame for receive and sets the strength level
`timescale 1ns/1ps

module rxs_modem_model (
  // bench control
  input wire logic frame,
  input wire logic [7:0] level,
  // modem pins
  output logic bit_clk,
  output logic preamble_det,
  output logic sync_det,
  output logic [7:0] raw_strength,
  output int bit_no
);
  // bit clock only inside frames, phase offset from pclk
  always begin
    bit_clk = 1'b0;
    bit_no = 0;
    preamble_det = 1'b0;
    sync_det = 1'b0;
    raw_strength = level;
    wait (frame === 1'b1);
    #7;
    raw_strength = level;
    while (frame === 1'b1) begin
      #80;
      bit_clk = 1'b1;
      bit_no++;
      preamble_det = bit_no >= 8;
      sync_det = bit_no >= 12;
      #80;
      bit_clk = 1'b0;
      raw_strength = level; // stable around rising edges
    end
  end
endmodule // rxs_modem_model
